// ===== hdl/flash_program_control_defs.svh
// Purpose: Named constants for the flash programming controller.
// Assumes: Included by every design file that needs an offset, field or code.
// Notes:   Definitions only; no logic lives here.
`ifndef FLASH_PROGRAM_CONTROL_DEFS_SVH
`define FLASH_PROGRAM_CONTROL_DEFS_SVH

// Special-function-register address of flash_control.
`define FLASH_CONTROL_ADDR 8'hD1
// Reset value of flash_control.
`define FLASH_CONTROL_RESET 8'h00
// Field positions inside flash_control.
`define LAUNCH_HI 7
`define LAUNCH_LO 4
`define PAGE_MAP_BIT 3
`define SPACE_HI 2
`define SPACE_LO 1
`define BUSY_BIT 0
// Launch command patterns written to the launch field.
`define LAUNCH_ARM 4'h5
`define LAUNCH_GO 4'hA
// Code address landmarks.
`define BOOT_BASE 16'hF800
`define USER_TOP 16'h7FFF
// Page geometry: byte index bits and page bits of a load address.
`define INDEX_HI 6
`define PAGE_HI 14
`define PAGE_LO 7
`define LAST_INDEX 7'h7F
`define FIRST_INDEX 7'h00
// Protection levels.
`define LEVEL_ONE 3'h1
`define LEVEL_TWO 3'h2
`define LEVEL_THREE 3'h3
`define LEVEL_FOUR 3'h4

`endif

// ===== hdl/flash_program_control_pkg.sv
// Purpose: Types shared by the flash programming controller and its helpers.
// Assumes: Constants come from flash_program_control_defs.svh.
// Notes:   Enums and packed structs only.
package flash_program_control_pkg;

  // Space-select field encoding.
  typedef enum logic [1:0] {
    SPACE_USER     = 2'h0,
    SPACE_EXTRA    = 2'h1,
    SPACE_SECURITY = 2'h2,
    SPACE_RESERVED = 2'h3
  } space_e;

  // Where the CPU is executing from when it makes an access.
  typedef enum logic [1:0] {
    EXEC_USER     = 2'h0,
    EXEC_BOOT     = 2'h1,
    EXEC_EXTERNAL = 2'h2,
    EXEC_SPARE    = 2'h3
  } exec_region_e;

  // Target of a code read after mapping and protection.
  typedef enum logic [2:0] {
    TGT_USER     = 3'h0,
    TGT_BOOT     = 3'h1,
    TGT_EXTRA    = 3'h2,
    TGT_SECURITY = 3'h3,
    TGT_EXTERNAL = 3'h4,
    TGT_NONE     = 3'h5
  } target_e;

  // Programming sequencer states.
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_ERASE = 3'b010,
    SEQ_PROG  = 3'b100
  } seq_state_e;

  // Launch detector states.
  typedef enum logic [2:0] {
    ARM_IDLE = 3'b001,
    ARM_SAME = 3'b010,
    ARM_NEXT = 3'b100
  } arm_state_e;

  // One operation on the flash array.
  typedef struct packed {
    logic        erase;
    space_e      space;
    logic [14:0] addr;
    logic [7:0]  data;
  } nvm_cmd_s;

  // Result of mapping one code read.
  typedef struct packed {
    target_e     tgt;
    logic [15:0] addr;
  } code_map_s;

endpackage

// ===== hdl/page_buffer.sv
// Purpose: Column-latch page buffer of 128 bytes with a loaded mask.
// Assumes: Loads come from the controller already qualified.
// Notes:   Storage is flip-flops; the read index muxes them directly.
`timescale 1ns/1ps
`include "flash_program_control_defs.svh"
module page_buffer
  import flash_program_control_pkg::*;
(
  input  wire logic         sys_clk_in,      // System clock.
  input  wire logic         rst_b_in,        // Asynchronous reset, active low.
  input  wire logic         load_in,         // Store one byte this cycle.
  input  wire logic [14:0]  load_addr_in,    // Page and byte index of the load.
  input  wire logic [7:0]   load_data_in,    // Byte to store.
  input  wire logic         clear_in,        // Forget every loaded byte.
  input  wire logic [6:0]   rd_index_in,     // Byte index to read back.
  output logic      [7:0]   rd_data_out,     // Stored byte at rd_index_in.
  output logic      [127:0] loaded_out,      // One bit per loaded byte.
  output logic      [7:0]   page_out         // Page of the latest load.
);

  logic [7:0] byte_ff [128];                 // Latched data bytes.
  logic [127:0] loaded_ff;                   // Which bytes were loaded.
  logic [7:0] page_ff;                       // Page of the latest load.

  // One latch per byte; only the addressed one updates on a load.
  for (genvar i = 0; i < 128; i++) begin : g_byte
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        byte_ff[i]   <= 8'h00;
        loaded_ff[i] <= 1'b0;
      end else if (load_in && (load_addr_in[`INDEX_HI:0] == 7'(i))) begin
        byte_ff[i]   <= load_data_in;
        loaded_ff[i] <= 1'b1;
      end else if (clear_in) begin
        loaded_ff[i] <= 1'b0;
      end
    end
  end

  // The latest load names the page; earlier loads of other pages lose.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      page_ff <= 8'h00;
    end else if (load_in) begin
      page_ff <= load_addr_in[`PAGE_HI:`PAGE_LO];
    end
  end

  assign rd_data_out = byte_ff[rd_index_in];
  assign loaded_out  = loaded_ff;
  assign page_out    = page_ff;

endmodule // page_buffer

// ===== hdl/launch_detector.sv
// Purpose: Recognises the two-write launch pattern on the launch field.
// Assumes: instr_end_in pulses once at the end of every CPU instruction.
// Notes:   The arming write's own instruction end is allowed to pass.
`timescale 1ns/1ps
`include "flash_program_control_defs.svh"
module launch_detector
  import flash_program_control_pkg::*;
(
  input  wire logic       sys_clk_in,        // System clock.
  input  wire logic       rst_b_in,          // Asynchronous reset, active low.
  input  wire logic       ctl_wr_in,         // Write to flash_control.
  input  wire logic [3:0] launch_nibble_in,  // Launch field of that write.
  input  wire logic       instr_end_in,      // End of a CPU instruction.
  input  wire logic       from_boot_in,      // Write issued from boot flash.
  input  wire logic       busy_in,           // Programming already running.
  output logic            go_out             // One-cycle launch pulse.
);

  arm_state_e arm_ff;                        // Progress through the pattern.
  arm_state_e nxt_arm;
  logic       is_arm;
  logic       is_go;

  assign is_arm = ctl_wr_in && (launch_nibble_in == `LAUNCH_ARM);
  assign is_go  = ctl_wr_in && (launch_nibble_in == `LAUNCH_GO);

  // Only an armed state turns the A pattern into a launch, and only from
  // boot flash while idle; a lone A pattern does nothing.
  assign go_out = is_go && (arm_ff != ARM_IDLE) && from_boot_in && !busy_in;

  // Any write other than the 5 pattern, the A pattern included, or a second
  // instruction end, drops the arming so an intervening instruction aborts.
  always_comb begin
    nxt_arm = arm_ff;
    case (arm_ff)
      ARM_IDLE: begin
        if (is_arm) begin
          nxt_arm = ARM_SAME;
        end
      end
      ARM_SAME: begin
        if (ctl_wr_in) begin
          nxt_arm = is_arm ? ARM_SAME : ARM_IDLE;
        end else if (instr_end_in) begin
          nxt_arm = ARM_NEXT;
        end
      end
      ARM_NEXT: begin
        if (ctl_wr_in) begin
          nxt_arm = is_arm ? ARM_SAME : ARM_IDLE;
        end else if (instr_end_in) begin
          nxt_arm = ARM_IDLE;
        end
      end
      default: begin
        nxt_arm = ARM_IDLE;
      end
    endcase
  end

  // Arming register.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arm_ff <= ARM_IDLE;
    end else begin
      arm_ff <= nxt_arm;
    end
  end

endmodule // launch_detector

// ===== hdl/flash_program_control.sv
// Purpose: Flash programming controller: control register, page buffer,
//          protected launch, busy flag, code read mapping and protection.
// Assumes: CPU core, flash array and lock bits all run on sys_clk_in.
// Notes:   The external-access pin is the only asynchronous input besides rst_b_in.
`timescale 1ns/1ps
`include "flash_program_control_defs.svh"
module flash_program_control
  import flash_program_control_pkg::*;
(
  input  wire logic          sys_clk_in,          // 10 MHz system clock.
  input  wire logic          rst_b_in,            // Asynchronous reset, active low.
  input  wire logic [7:0]    sfr_addr_in,         // Special-function-register address.
  input  wire logic          sfr_wr_in,           // Register write strobe.
  input  wire logic          sfr_rd_in,           // Register read strobe.
  input  wire logic [7:0]    sfr_wdata_in,        // Register write data.
  output logic      [7:0]    sfr_rdata_out,       // Register read data.
  input  wire logic          instr_end_in,        // End of each instruction.
  input  wire exec_region_e  exec_region_in,      // Where code is executing.
  input  wire logic          boot_flash_map_enable_in, // Boot map bit from the core.
  input  wire logic          xdata_wr_in,         // External-data write strobe.
  input  wire logic [15:0]   xdata_addr_in,       // Data pointer of the write.
  input  wire logic [7:0]    xdata_wdata_in,      // Accumulator byte written.
  output logic               xdata_to_latch_out,  // Write went to the page buffer.
  input  wire logic          code_rd_in,          // Code read request.
  input  wire logic          code_fetch_in,       // Request is an instruction fetch.
  input  wire logic [15:0]   code_addr_in,        // Code address.
  output code_map_s          code_map_out,        // Mapped target of the read.
  output logic               rollover_block_out,  // Fetch refused past user top.
  output logic               nvm_req_out,         // Array operation requested.
  output nvm_cmd_s           nvm_cmd_out,         // Array operation details.
  input  wire logic          nvm_ack_in,          // Array finished the operation.
  input  wire logic          lock_bit_a_in,       // Programmed when high.
  input  wire logic          lock_bit_b_in,       // Programmed when high.
  input  wire logic          lock_bit_c_in,       // Programmed when high.
  input  wire logic          external_access_select_in, // Pin, asynchronous.
  output logic               external_access_select_out, // Access select in force.
  output logic               parallel_prog_block_out,   // Parallel writes barred.
  output logic               parallel_verify_block_out, // Parallel verify barred.
  output logic [2:0]         protection_level_out        // Level 1 to 4.
);

  logic [7:1]  ctl_ff;            // Stored launch, page-map and space fields.
  seq_state_e  state_ff;          // Programming sequencer state.
  seq_state_e  nxt_state;
  space_e      op_space_ff;       // Space chosen by the launching write.
  logic [6:0]  idx_ff;            // Byte index being worked on.
  logic        req_ff;            // Array request outstanding.
  nvm_cmd_s    cmd_ff;            // Command held for the array.
  logic [2:0]  level_ff;          // Protection level in force.
  logic        captured_ff;       // Straps taken after reset release.
  logic        acs_meta_ff;       // Pin synchroniser, first stage.
  logic        acs_sync_ff;       // Pin synchroniser, second stage.
  logic        acs_latch_ff;      // Access select frozen at reset.
  logic [7:0]  rdata_ff;          // Read data register.
  code_map_s   map_ff;            // Registered code mapping.
  logic        roll_ff;           // Registered rollover refusal.
  logic        ctl_wr;
  logic        busy;
  logic        go;
  logic        load;
  logic        clear;
  logic        use_byte;
  logic        last;
  logic [127:0] loaded;
  logic [7:0]  page;
  logic [7:0]  buf_data;
  code_map_s   map_now;

  assign ctl_wr = sfr_wr_in && (sfr_addr_in == `FLASH_CONTROL_ADDR);
  assign busy   = (state_ff != SEQ_IDLE);

  // Data writes go to the buffer while bit 3 is set, except from external
  // code, and never while a page is being written back.
  assign load = xdata_wr_in && ctl_ff[`PAGE_MAP_BIT] && !busy
             && (exec_region_in != EXEC_EXTERNAL);
  assign xdata_to_latch_out = load;

  page_buffer i_page_buffer (
    .sys_clk_in   (sys_clk_in),
    .rst_b_in     (rst_b_in),
    .load_in      (load),
    .load_addr_in (xdata_addr_in[`PAGE_HI:0]),
    .load_data_in (xdata_wdata_in),
    .clear_in     (clear),
    .rd_index_in  (idx_ff),
    .rd_data_out  (buf_data),
    .loaded_out   (loaded),
    .page_out     (page)
  );

  launch_detector i_launch_detector (
    .sys_clk_in       (sys_clk_in),
    .rst_b_in         (rst_b_in),
    .ctl_wr_in        (ctl_wr),
    .launch_nibble_in (sfr_wdata_in[`LAUNCH_HI:`LAUNCH_LO]),
    .instr_end_in     (instr_end_in),
    .from_boot_in     (exec_region_in == EXEC_BOOT),
    .busy_in          (busy),
    .go_out           (go)
  );

  // Control register; bit 0 is never stored from software.
  // Writes are refused while busy so the running space cannot change.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_ff <= 7'(`FLASH_CONTROL_RESET >> 1);
    end else if (ctl_wr && !busy) begin
      ctl_ff <= sfr_wdata_in[7:1];
    end
  end

  // Registered read port; only flash_control answers, others read zero.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_ff <= 8'h00;
    end else if (sfr_rd_in) begin
      rdata_ff <= (sfr_addr_in == `FLASH_CONTROL_ADDR) ? {ctl_ff, busy} : 8'h00;
    end
  end
  assign sfr_rdata_out = rdata_ff;

  // The security byte is a single location, so only byte 0 is used.
  // A reserved space uses no byte at all, though the walk still runs.
  assign use_byte = loaded[idx_ff] && (op_space_ff != SPACE_RESERVED)
                 && ((op_space_ff != SPACE_SECURITY) || (idx_ff == `FIRST_INDEX));
  assign last  = (idx_ff == `LAST_INDEX) && (!use_byte || (req_ff && nvm_ack_in));
  assign clear = (state_ff == SEQ_PROG) && last;

  // Sequencer: erase every byte that use_byte selects, then program the same bytes.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SEQ_IDLE: begin
        if (go) begin
          nxt_state = SEQ_ERASE;
        end
      end
      SEQ_ERASE: begin
        if (last) begin
          nxt_state = SEQ_PROG;
        end
      end
      SEQ_PROG: begin
        if (last) begin
          nxt_state = SEQ_IDLE;
        end
      end
      default: begin
        nxt_state = SEQ_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= SEQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The launching write's own space field picks the target space.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op_space_ff <= SPACE_USER;
    end else if (go) begin
      op_space_ff <= space_e'(sfr_wdata_in[`SPACE_HI:`SPACE_LO]);
    end
  end

  // Byte walker: skips bytes that use_byte leaves out in one cycle, waits for
  // the array on used ones; wraps to zero between the two phases.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx_ff <= `FIRST_INDEX;
    end else if (state_ff == SEQ_IDLE) begin
      idx_ff <= `FIRST_INDEX;
    end else if (!use_byte || (req_ff && nvm_ack_in)) begin
      idx_ff <= idx_ff + 7'h01;
    end
  end

  // Array request and command; in user space the page comes from the latest load, otherwise it is zero.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_ff <= 1'b0;
      cmd_ff <= '0;
    end else if (req_ff) begin
      req_ff <= !nvm_ack_in;
    end else if (busy && use_byte) begin
      req_ff         <= 1'b1;
      cmd_ff.erase   <= (state_ff == SEQ_ERASE);
      cmd_ff.space   <= op_space_ff;
      cmd_ff.addr    <= (op_space_ff == SPACE_USER) ? {page, idx_ff}
                                                    : {8'h00, idx_ff};
      cmd_ff.data    <= buf_data;
    end
  end
  assign nvm_req_out = req_ff;
  assign nvm_cmd_out = cmd_ff;

  // Access-select pin synchroniser.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acs_meta_ff <= 1'b0;
      acs_sync_ff <= 1'b0;
    end else begin
      acs_meta_ff <= external_access_select_in;
      acs_sync_ff <= acs_meta_ff;
    end
  end

  // Lock level and access select are taken once after reset release; the
  // level stays at 4 until then, and software has no path to it.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_ff    <= `LEVEL_FOUR;
      captured_ff <= 1'b0;
      acs_latch_ff <= 1'b0;
    end else if (!captured_ff) begin
      captured_ff <= 1'b1;
      acs_latch_ff <= acs_sync_ff;
      if (lock_bit_c_in) begin
        level_ff <= `LEVEL_FOUR;
      end else if (lock_bit_b_in) begin
        level_ff <= `LEVEL_THREE;
      end else if (lock_bit_a_in) begin
        level_ff <= `LEVEL_TWO;
      end else begin
        level_ff <= `LEVEL_ONE;
      end
    end
  end

  // Level 1 follows the live pin; from level 2 the reset value is kept.
  assign external_access_select_out = (level_ff == `LEVEL_ONE) ? acs_sync_ff
                                                               : acs_latch_ff;
  assign parallel_prog_block_out   = (level_ff >= `LEVEL_TWO);
  assign parallel_verify_block_out = (level_ff >= `LEVEL_THREE);
  assign protection_level_out      = level_ff;

  // Maps one code read to its space. External code never reaches a flash
  // space; it reads only external code whatever the level.
  function automatic code_map_s map_code(input logic [1:0] sel,
                                         input logic boot_en,
                                         input exec_region_e region,
                                         input logic fetch,
                                         input logic [15:0] addr);
    code_map_s   m;
    logic        boot_hit;
    m        = '{tgt: TGT_EXTERNAL, addr: addr};
    boot_hit = boot_en && (addr >= `BOOT_BASE);
    if (region == EXEC_EXTERNAL) begin
      m.tgt = TGT_EXTERNAL;
    end else if (fetch || (sel == 2'h0)) begin
      if (boot_hit) begin
        m.tgt = TGT_BOOT;
      end else if (addr <= `USER_TOP) begin
        m.tgt = TGT_USER;
      end
    end else if (sel == 2'h1) begin
      m.addr = {9'h000, addr[`INDEX_HI:0]};
      m.tgt  = (region == EXEC_BOOT) ? TGT_EXTRA : TGT_NONE;
    end else if (sel == 2'h2) begin
      m.addr = 16'h0000;
      m.tgt  = TGT_SECURITY;
    end else begin
      m.tgt = (addr <= `USER_TOP) ? TGT_USER : TGT_NONE;
    end
    return m;
  endfunction

  assign map_now = map_code(ctl_ff[`SPACE_HI:`SPACE_LO], boot_flash_map_enable_in,
                            exec_region_in, code_fetch_in, code_addr_in);

  // Code read result; at level 4 an internal fetch rolling past the user
  // top into external space is refused instead of executed.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      map_ff  <= '{tgt: TGT_NONE, addr: 16'h0000};
      roll_ff <= 1'b0;
    end else if (code_rd_in) begin
      roll_ff <= 1'b0;
      map_ff  <= map_now;
      if (code_fetch_in && (exec_region_in != EXEC_EXTERNAL)
          && (map_now.tgt == TGT_EXTERNAL) && (level_ff == `LEVEL_FOUR)) begin
        map_ff.tgt <= TGT_NONE;
        roll_ff    <= 1'b1;
      end
    end
  end
  assign code_map_out       = map_ff;
  assign rollover_block_out = roll_ff;

endmodule // flash_program_control

// ===== bench/flash_program_control_assertions.sv
// Purpose: Port checks for the flash programming controller.
// Assumes: Lock bits change only while reset is low.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/1ps
module flash_program_control_assertions
  import flash_program_control_pkg::*;
(
  input wire logic         sys_clk_in, rst_b_in, sfr_rd_in, xdata_wr_in, xdata_to_latch_out,
  input wire logic         code_rd_in, code_fetch_in, boot_flash_map_enable_in,
  input wire logic         rollover_block_out, nvm_req_out, nvm_ack_in,
  input wire logic         lock_bit_a_in, lock_bit_b_in, lock_bit_c_in,
  input wire logic [7:0]   sfr_addr_in, sfr_rdata_out,
  input wire logic [15:0]  code_addr_in,
  input wire logic [2:0]   protection_level_out,
  input wire exec_region_e exec_region_in,
  input wire code_map_s    code_map_out,
  input wire nvm_cmd_s     nvm_cmd_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // A request still waiting for the array, and a fetch made by boot code.
  sequence s_wait; nvm_req_out && !nvm_ack_in; endsequence
  sequence s_boot; code_rd_in && code_fetch_in && exec_region_in == EXEC_BOOT; endsequence
  a_req_held: assert property (s_wait |=> nvm_req_out && $stable(nvm_cmd_out))
    else $error("array request changed before its answer");
  a_req_gap: assert property (nvm_req_out && nvm_ack_in |=> !nvm_req_out)
    else $error("array request not lowered after answer");
  a_busy_read: assert property (nvm_req_out && sfr_rd_in && sfr_addr_in == 8'hD1 |=>
    sfr_rdata_out[0]) else $error("busy flag low during programming");
  a_latch_source: assert property (xdata_to_latch_out |-> xdata_wr_in && !nvm_req_out &&
    exec_region_in != EXEC_EXTERNAL) else $error("page buffer took a barred write");
  a_boot_map: assert property (s_boot ##0 boot_flash_map_enable_in &&
    code_addr_in >= 16'hF800 |=> code_map_out.tgt == TGT_BOOT) else $error("boot not mapped");
  a_ext_code: assert property (code_rd_in && exec_region_in == EXEC_EXTERNAL |=>
    code_map_out.tgt == TGT_EXTERNAL) else $error("external code reached flash");
  a_roll_block: assert property (code_rd_in && code_fetch_in && code_addr_in[15] &&
    exec_region_in == EXEC_USER && !boot_flash_map_enable_in && protection_level_out == 3'h4
    |=> rollover_block_out) else $error("rollover fetch not blocked");
  a_level_one: assert property ((!lock_bit_a_in && !lock_bit_b_in && !lock_bit_c_in) [*3]
    |-> protection_level_out == 3'h1) else $error("level one not reported");
  a_level_four: assert property (lock_bit_c_in [*3] |-> protection_level_out == 3'h4)
    else $error("level four not reported");
endmodule // flash_program_control_assertions
bind flash_program_control flash_program_control_assertions i_chk (.*);

// ===== bench/nvm_array_model.sv
// Purpose: Flash array stand-in that answers each requested operation.
// Assumes: Requests hold until answered.
// Notes:   Waits zero to three cycles at random, so prompt and slow answers both occur.
`timescale 1ns/1ps
module nvm_array_model (
  input  wire logic sys_clk_in,  // System clock.
  input  wire logic rst_b_in,    // Asynchronous reset, active low.
  input  wire logic nvm_req_in,  // Operation requested.
  output logic      nvm_ack_out  // One-cycle completion pulse.
);
  int unsigned wait_q;  // Cycles left before answering.
  // Driven on the falling edge so the controller samples a settled pulse.
  always @(negedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nvm_ack_out <= 1'b0;
      wait_q      <= 0;
    end else if (nvm_req_in && !nvm_ack_out && wait_q == 0) begin
      nvm_ack_out <= 1'b1;
    end else begin
      nvm_ack_out <= 1'b0;
      wait_q      <= (nvm_req_in && !nvm_ack_out) ? wait_q - 1 : $urandom_range(3, 0);
    end
  end
endmodule // nvm_array_model

// ===== bench/test_flash_program_control.sv
// Purpose: Self-checking bench for the flash programming controller.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Expected array operations and register reads wait in queues.
`timescale 1ns/1ps
module test_flash_program_control
  import flash_program_control_pkg::*;
;
  logic sys_clk_in = 0, rst_b_in = 0, sfr_wr_in = 0, sfr_rd_in = 0, instr_end_in = 0, rd_d = 0;
  logic xdata_wr_in = 0, code_rd_in = 0, code_fetch_in = 0, boot_flash_map_enable_in = 0;
  logic lock_bit_a_in = 0, lock_bit_b_in = 0, lock_bit_c_in = 0, external_access_select_in = 1;
  logic nvm_ack_in, nvm_req_out, xdata_to_latch_out;
  logic [7:0] sfr_addr_in = 8'hD1, sfr_wdata_in = 0, xdata_wdata_in = 0, sfr_rdata_out, pg;
  logic [15:0] xdata_addr_in = 0, code_addr_in = 0;
  logic [14:0] av[3];
  logic [7:0] dv[3], rq[$];
  logic [6:0] ix;
  exec_region_e exec_region_in = EXEC_BOOT;
  code_map_s code_map_out;
  nvm_cmd_s nvm_cmd_out, oq[$];
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  flash_program_control i_flash_program_control (.*, .rollover_block_out(),
    .external_access_select_out(), .parallel_prog_block_out(), .parallel_verify_block_out(),
    .protection_level_out());
  nvm_array_model i_nvm_array_model (.sys_clk_in, .rst_b_in, .nvm_req_in(nvm_req_out),
    .nvm_ack_out(nvm_ack_in));
  task chk_reg(logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] flash_control expected %h seen %h", e, g);
    end
  endtask
  // Erase operations carry no data, so only programming data is compared.
  task chk_op(nvm_cmd_s e, nvm_cmd_s g);
    cmp_count++;
    if (e.erase) g.data = e.data;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] nvm_cmd expected %h seen %h", e, g);
    end
  endtask
  // Monitors take the oldest note whenever a result appears.
  always @(posedge sys_clk_in) begin
    rd_d <= sfr_rd_in;
    cyc++;
    if (nvm_req_out && nvm_ack_in) chk_op(oq.size() ? oq.pop_front() : '1, nvm_cmd_out);
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  always @(negedge sys_clk_in) if (rd_d && rq.size() > 0) chk_reg(rq.pop_front(), sfr_rdata_out);
  task wr(logic [7:0] d);
    @(negedge sys_clk_in) sfr_wdata_in = d;
    sfr_wr_in = 1;
    @(negedge sys_clk_in) sfr_wr_in = 0;
  endtask
  task rd(logic [7:0] e);
    @(negedge sys_clk_in) sfr_rd_in = 1;
    rq.push_back(e);
    @(negedge sys_clk_in) sfr_rd_in = 0;
  endtask
  task ld(logic [15:0] a, logic [7:0] d);
    @(negedge sys_clk_in) {xdata_addr_in, xdata_wdata_in, xdata_wr_in} = {a, d, 1'b1};
    @(negedge sys_clk_in) xdata_wr_in = 0;
  endtask
  task cr(logic f, logic [15:0] a);
    @(negedge sys_clk_in) {code_fetch_in, code_addr_in, code_rd_in} = {f, a, 1'b1};
    @(negedge sys_clk_in) code_rd_in = 0;
  endtask
  task exp_ops(space_e s, int n);
    for (int e = 1; e >= 0; e--) for (int k = 0; k < n; k++) oq.push_back('{e[0], s, av[k], dv[k]});
  endtask
  // Arm, let instruction ends pass, fire, read busy, poll until idle, then clear.
  task launch(logic [3:0] lo, int ends, logic b, string n);
    wr({4'h5, lo});
    repeat (ends) begin
      @(negedge sys_clk_in) instr_end_in = 1;
      @(negedge sys_clk_in) instr_end_in = 0;
    end
    wr({4'hA, lo});
    rd({4'hA, lo[3:1], b});
    repeat (600) begin
      @(negedge sys_clk_in) sfr_rd_in = 1;
      @(negedge sys_clk_in) sfr_rd_in = 0;
      if (sfr_rdata_out[0] === 1'b0) break;
    end
    rd({4'hA, lo[3:1], 1'b0});
    if (oq.size() > 0) begin
      miscompares++;
      $display("[FAIL] nvm_cmd expected none left seen %0d", oq.size());
    end
    wr(8'h00);
    $display("Test %s finished", n);
  endtask
  task stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(6125));
    pg = $urandom;
    ix = $urandom_range(126, 1);
    foreach (dv[k]) dv[k] = $urandom;
    repeat (10) @(negedge sys_clk_in);
    rst_b_in = 1;
    rd(8'h00);
    wr(8'h0D);
    rd(8'h0C);
    av = '{{pg, 7'h00}, {pg, ix}, {pg, 7'h7F}};
    wr(8'h08);
    ld({1'b0, pg + 8'h01, 7'h7F}, dv[2]);
    ld({1'b0, pg + 8'h01, ix}, dv[1]);
    ld({1'b0, pg, 7'h00}, dv[0]);
    exp_ops(SPACE_USER, 3);
    launch(4'h0, 1, 1'b1, "user page");
    exec_region_in = EXEC_USER;
    launch(4'h0, 1, 1'b0, "launch from user code");
    exec_region_in = EXEC_BOOT;
    launch(4'h0, 2, 1'b0, "split launch");
    wr(8'hA0);
    rd(8'hA0);
    wr(8'h08);
    av[0] = 15'h0000;
    av[1] = 15'h0055;
    ld(16'hFF80, dv[0]);
    ld(16'hFFD5, dv[1]);
    exp_ops(SPACE_EXTRA, 2);
    launch(4'h2, 1, 1'b1, "extra row");
    wr(8'h0C);
    ld(16'h0000, dv[0]);
    exp_ops(SPACE_SECURITY, 1);
    launch(4'h4, 1, 1'b1, "security byte");
    launch(4'h6, 1, 1'b1, "reserved space");
    wr(8'h08);
    exec_region_in = EXEC_EXTERNAL;
    ld(16'h0010, 8'h5A);
    cr(1'b0, 16'h0010);
    exec_region_in = EXEC_BOOT;
    boot_flash_map_enable_in = 1;
    cr(1'b1, 16'hF9A0);
    launch(4'h0, 1, 1'b1, "external load refused");
    @(negedge sys_clk_in) rst_b_in = 0;
    lock_bit_c_in = 1;
    repeat (10) @(negedge sys_clk_in);
    {rst_b_in, boot_flash_map_enable_in, exec_region_in} = {1'b1, 1'b0, EXEC_USER};
    repeat (3) @(negedge sys_clk_in);
    cr(1'b1, 16'h8000);
    @(negedge sys_clk_in);
    stop_test();
  end
endmodule // test_flash_program_control
